// >>> design/counter_array_cycle_and_module_mode.sv
// Cycle length, cycle wrap flag and per-module mode logic of the counter array
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: Wrap flag sets when the counter carries out of the selected bit 7 to 10.
// R2: Wrap flag is set by hardware or software write, cleared only by software.
// R3: Bits 4:2 of the cycle config register read zero, writes ignored.
// R4: Selector 00, 01, 10, 11 picks an 8, 9, 10 or 11 bit cycle.
// R5: The shared cycle length drives every PWM module not in 16-bit mode.
// R6: Modules in 16-bit PWM ignore the shared cycle length selector.
// R7: Mode bit 7 picks 8-to-11-bit PWM when clear and 16-bit when set.
// R8: Mode bit 6 enables comparison of the counter with the module value.
// R9: Mode bit 5 captures the counter on a rising input edge.
// R10: Mode bit 4 captures the counter on a falling input edge.
// R11: Three 8-bit mode registers at 0xDA, 0xDB, 0xDC, read/write, reset zero.
// R12: With wrap interrupt enabled, a set wrap flag raises the array interrupt.
// R13: With mode bit 3 set, a compare match sets the module event flag.
// R14: Mode bit 2 toggles the output on match; with PWM it is frequency output.
// R15: Mode bit 1 drives a PWM waveform whose width follows the 16-bit select.
// R16: A hardware wrap in the same cycle as a software clear leaves it set.
// R17: With both capture enables set, every input transition captures.
module counter_array_cycle_and_module_mode (
	// Clock and reset
	input  wire logic                                      clk,
	input  wire logic                                      rstn,
	// Special-function-register access
	input  wire counter_array_pkg::sfr_req_t               sfrReq,
	output var  logic [7:0]                                sfrRdData,
	// Array counter
	input  wire logic [15:0]                               arrayCounter,
	input  wire logic                                      counterTick,
	// Per-module compare values, capture inputs and event flag clears
	input  wire logic [counter_array_pkg::NUM_MODULES-1:0][15:0] compareValue,
	input  wire logic [counter_array_pkg::NUM_MODULES-1:0]       captureIn,
	input  wire logic [counter_array_pkg::NUM_MODULES-1:0]       moduleFlagClear,
	// Per-module results
	output var  logic [counter_array_pkg::NUM_MODULES-1:0]       moduleOutputPin,
	output var  logic [counter_array_pkg::NUM_MODULES-1:0]       moduleEventFlag,
	output var  logic [counter_array_pkg::NUM_MODULES-1:0][15:0] capturedValue,
	// Interrupt request
	output var  logic                                      arrayIrq
);

	// ************************************************************
	// Cycle configuration register and wrap detection
	// ************************************************************
	counter_array_pkg::pwm_cycle_config_t cycleConfig;
	counter_array_pkg::pwm_cycle_config_t next_cycleConfig;
	logic [15:0]                          cycleMask;
	logic                                 wrapEvent;
	logic                                 configWrite;

	always_comb begin
		unique case (cycleConfig.cycleLengthSelect) // R4
			counter_array_pkg::CYCLE_8_BITS:  cycleMask = counter_array_pkg::CYCLE_MASK_8;
			counter_array_pkg::CYCLE_9_BITS:  cycleMask = counter_array_pkg::CYCLE_MASK_9;
			counter_array_pkg::CYCLE_10_BITS: cycleMask = counter_array_pkg::CYCLE_MASK_10;
			counter_array_pkg::CYCLE_11_BITS: cycleMask = counter_array_pkg::CYCLE_MASK_11;
		endcase
	end

	// Carry out of the top cycle bit happens on the tick that leaves it all ones
	assign wrapEvent   = counterTick && ((arrayCounter & cycleMask) == cycleMask); // R1
	assign configWrite = sfrReq.wr && (sfrReq.addr == counter_array_pkg::ADDR_PWM_CYCLE_CONFIG);

	always_comb begin
		next_cycleConfig = cycleConfig;
		if (configWrite) begin
			next_cycleConfig = counter_array_pkg::pwm_cycle_config_t'(sfrReq.wrData);
		end
		next_cycleConfig.unused = counter_array_pkg::UNUSED_FIELD_VALUE; // R3
		if (wrapEvent) begin
			next_cycleConfig.cycleWrapFlag = 1'b1; // R1 R2 R16
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cycleConfig <= counter_array_pkg::pwm_cycle_config_t'(
				counter_array_pkg::PWM_CYCLE_CONFIG_RESET);
		end else begin
			cycleConfig <= next_cycleConfig;
		end
	end

	// ************************************************************
	// Module mode registers
	// ************************************************************
	counter_array_pkg::module_mode_t [counter_array_pkg::NUM_MODULES-1:0] moduleMode;
	counter_array_pkg::module_mode_t [counter_array_pkg::NUM_MODULES-1:0] next_moduleMode;

	logic [counter_array_pkg::NUM_MODULES-1:0][7:0] modeAddr;
	assign modeAddr[0] = counter_array_pkg::ADDR_MODULE0_MODE;
	assign modeAddr[1] = counter_array_pkg::ADDR_MODULE1_MODE;
	assign modeAddr[2] = counter_array_pkg::ADDR_MODULE2_MODE;

	always_comb begin
		next_moduleMode = moduleMode;
		for (int m = 0; m < counter_array_pkg::NUM_MODULES; m++) begin
			if (sfrReq.wr && (sfrReq.addr == modeAddr[m])) begin
				next_moduleMode[m] = counter_array_pkg::module_mode_t'(sfrReq.wrData); // R11
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int m = 0; m < counter_array_pkg::NUM_MODULES; m++) begin
				moduleMode[m] <= counter_array_pkg::module_mode_t'(
					counter_array_pkg::MODULE_MODE_RESET); // R11
			end
		end else begin
			moduleMode <= next_moduleMode;
		end
	end

	// ************************************************************
	// Register read path
	// ************************************************************
	logic [7:0] next_sfrRdData;

	always_comb begin
		next_sfrRdData = sfrRdData;
		if (sfrReq.rd) begin
			next_sfrRdData = counter_array_pkg::UNMAPPED_READ_VALUE;
			if (sfrReq.addr == counter_array_pkg::ADDR_PWM_CYCLE_CONFIG) begin
				next_sfrRdData = cycleConfig; // R3
			end
			for (int m = 0; m < counter_array_pkg::NUM_MODULES; m++) begin
				if (sfrReq.addr == modeAddr[m]) begin
					next_sfrRdData = moduleMode[m]; // R11
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfrRdData <= counter_array_pkg::UNMAPPED_READ_VALUE;
		end else begin
			sfrRdData <= next_sfrRdData;
		end
	end

	// ************************************************************
	// Per-module compare, capture and output logic
	// ************************************************************
	logic [counter_array_pkg::NUM_MODULES-1:0] moduleIrqTerm;

	genvar g;
	generate
		for (g = 0; g < counter_array_pkg::NUM_MODULES; g++) begin : gModule
			counter_array_pkg::module_mode_t mode;
			logic                            capturePrev;
			logic                            next_capturePrev;
			logic                            next_pin;
			logic                            next_flag;
			logic [15:0]                     next_captured;
			logic                            compareMatch;
			logic                            freqMatch;
			logic                            riseEdge;
			logic                            fallEdge;
			logic                            captureEvent;
			logic                            pwmHigh;
			logic [15:0]                     pwmMask;

			assign mode = moduleMode[g];

			// Wide PWM spans the full counter; otherwise the shared length applies
			assign pwmMask = mode.widePwmSelect ? 16'hffff : cycleMask; // R5 R6 R7
			assign pwmHigh = (arrayCounter & pwmMask) < (compareValue[g] & pwmMask); // R15

			assign compareMatch = mode.compareFunctionEnable && counterTick
				&& (arrayCounter == compareValue[g]); // R8
			assign freqMatch = mode.compareFunctionEnable && counterTick
				&& ((arrayCounter[7:0] & counter_array_pkg::FREQ_MATCH_MASK)
				== (compareValue[g][7:0] & counter_array_pkg::FREQ_MATCH_MASK));

			assign riseEdge     = captureIn[g] && !capturePrev;
			assign fallEdge     = !captureIn[g] && capturePrev;
			assign captureEvent = (mode.risingCaptureEnable && riseEdge) // R9 R17
				|| (mode.fallingCaptureEnable && fallEdge); // R10 R17

			always_comb begin
				next_capturePrev = captureIn[g];
				next_captured    = capturedValue[g];
				if (captureEvent) begin
					next_captured = arrayCounter; // R9 R10
				end

				next_flag = moduleEventFlag[g];
				if (moduleFlagClear[g]) begin
					next_flag = 1'b0;
				end
				// Set after the clear so an event in the clearing cycle is kept
				if ((compareMatch && mode.matchFlagEnable) || captureEvent) begin
					next_flag = 1'b1; // R13
				end

				next_pin = moduleOutputPin[g];
				if (mode.pulseModEnable && mode.outputToggleEnable) begin
					if (freqMatch) begin
						next_pin = !moduleOutputPin[g]; // R14
					end
				end else if (mode.pulseModEnable) begin
					next_pin = pwmHigh; // R15
				end else if (mode.outputToggleEnable && compareMatch) begin
					next_pin = !moduleOutputPin[g]; // R14
				end
			end

			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					capturePrev        <= 1'b0;
					capturedValue[g]   <= 16'h0000;
					moduleEventFlag[g] <= 1'b0;
					moduleOutputPin[g] <= 1'b0;
				end else begin
					capturePrev        <= next_capturePrev;
					capturedValue[g]   <= next_captured;
					moduleEventFlag[g] <= next_flag;
					moduleOutputPin[g] <= next_pin;
				end
			end

			assign moduleIrqTerm[g] = mode.moduleEventIrqEnable && moduleEventFlag[g];
		end
	endgenerate

	// ************************************************************
	// Interrupt request
	// ************************************************************
	logic next_arrayIrq;

	always_comb begin
		next_arrayIrq = (cycleConfig.cycleWrapIrqEnable && cycleConfig.cycleWrapFlag) // R12
			|| (|moduleIrqTerm);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arrayIrq <= 1'b0;
		end else begin
			arrayIrq <= next_arrayIrq;
		end
	end

endmodule : counter_array_cycle_and_module_mode

`default_nettype wire

// >>> design/counter_array_pkg.sv
// Constants, field layouts and carrier types of the counter array configuration block
package counter_array_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [7:0] ADDR_MODULE0_MODE      = 8'hda;
	localparam logic [7:0] ADDR_MODULE1_MODE      = 8'hdb;
	localparam logic [7:0] ADDR_MODULE2_MODE      = 8'hdc;
	localparam logic [7:0] ADDR_PWM_CYCLE_CONFIG  = 8'hf7;

	// ************************************************************
	// Sizes and values after reset
	// ************************************************************
	localparam int         NUM_MODULES            = 3;
	localparam logic [7:0] MODULE_MODE_RESET      = 8'h00;
	localparam logic [7:0] PWM_CYCLE_CONFIG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;
	localparam logic [2:0] UNUSED_FIELD_VALUE     = 3'h0;
	localparam logic [7:0] FREQ_MATCH_MASK        = 8'hff;

	// ************************************************************
	// Cycle length encodings and the counter bits each one spans
	// ************************************************************
	typedef enum logic [1:0] {
		CYCLE_8_BITS  = 2'h0,
		CYCLE_9_BITS  = 2'h1,
		CYCLE_10_BITS = 2'h2,
		CYCLE_11_BITS = 2'h3
	} cycle_length_t;

	localparam logic [15:0] CYCLE_MASK_8  = 16'h00ff;
	localparam logic [15:0] CYCLE_MASK_9  = 16'h01ff;
	localparam logic [15:0] CYCLE_MASK_10 = 16'h03ff;
	localparam logic [15:0] CYCLE_MASK_11 = 16'h07ff;

	// ************************************************************
	// Field layouts
	// ************************************************************
	typedef struct packed {
		logic widePwmSelect;
		logic compareFunctionEnable;
		logic risingCaptureEnable;
		logic fallingCaptureEnable;
		logic matchFlagEnable;
		logic outputToggleEnable;
		logic pulseModEnable;
		logic moduleEventIrqEnable;
	} module_mode_t;

	typedef struct packed {
		logic          autoReloadSelect;
		logic          cycleWrapIrqEnable;
		logic          cycleWrapFlag;
		logic [2:0]    unused;
		cycle_length_t cycleLengthSelect;
	} pwm_cycle_config_t;

	// Special-function-register access, one cycle per strobe
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic       wr;
		logic       rd;
	} sfr_req_t;

endpackage : counter_array_pkg

// >>> tb/counter_array_assertions.sv
// Port-level checks of the counter array configuration block
`timescale 1ns/100ps
`default_nettype none
module counter_array_assertions (
	// Clock and reset
	input wire logic                        clk,
	input wire logic                        rstn,
	// Register access
	input wire counter_array_pkg::sfr_req_t sfrReq,
	input wire logic [7:0]                  sfrRdData,
	// Counter and module signals
	input wire logic [15:0]                 arrayCounter,
	input wire logic                        counterTick,
	input wire logic [2:0]                  captureIn,
	input wire logic [2:0]                  moduleFlagClear,
	input wire logic [2:0]                  moduleEventFlag,
	input wire logic [2:0][15:0]            capturedValue
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence modeWrite;
		sfrReq.wr && sfrReq.addr == 8'hda;
	endsequence
	sequence modeRead;
		sfrReq.rd && !sfrReq.wr && sfrReq.addr == 8'hda;
	endsequence
	sequence wrapEvent;
		counterTick && arrayCounter[10:0] == 11'h7ff;
	endsequence
	sequence cfgRead;
		sfrReq.rd && !sfrReq.wr && sfrReq.addr == 8'hf7;
	endsequence

	a_mode_readback: assert property (modeWrite ##1 modeRead |=>
		sfrRdData == $past(sfrReq.wrData, 2)) else $error("mode readback differs");
	a_unused_zero: assert property (cfgRead |=> sfrRdData[4:2] == 3'h0)
		else $error("unused config bits not zero");
	a_unmapped_zero: assert property (sfrReq.rd &&
		!(sfrReq.addr inside {8'hda, 8'hdb, 8'hdc, 8'hf7}) |=> sfrRdData == 8'h00)
		else $error("unmapped read not zero");
	a_rd_holds: assert property (!sfrReq.rd |=> $stable(sfrRdData))
		else $error("read data changed without read");
	a_wrap_sets: assert property (wrapEvent ##1 !sfrReq.wr ##1 cfgRead |=> sfrRdData[5])
		else $error("wrap flag not set after carry");
	a_flag_clear: assert property (moduleFlagClear[0] && !counterTick &&
		captureIn[0] == $past(captureIn[0]) |=> !moduleEventFlag[0]) else $error("flag not cleared");
	a_flag_cause: assert property (!moduleEventFlag[0] && !counterTick &&
		captureIn[0] == $past(captureIn[0]) |=> !moduleEventFlag[0]) else $error("flag without cause");
	a_capture_hold: assert property (captureIn[0] == $past(captureIn[0])
		|=> $stable(capturedValue[0])) else $error("capture without input edge");
endmodule : counter_array_assertions

bind counter_array_cycle_and_module_mode counter_array_assertions u_chk (.clk(clk),
	.rstn(rstn), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .arrayCounter(arrayCounter),
	.counterTick(counterTick), .captureIn(captureIn), .moduleFlagClear(moduleFlagClear),
	.moduleEventFlag(moduleEventFlag), .capturedValue(capturedValue));
`default_nettype wire

// >>> tb/tb_counter_array_cycle_and_module_mode.sv
// Self-checking bench for the counter array configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_counter_array_cycle_and_module_mode;
	logic                        clk = 1'b0;
	logic                        rstn = 1'b0;
	counter_array_pkg::sfr_req_t sfrReq = '0;
	logic [7:0]                  sfrRdData;
	logic [15:0]                 arrayCounter = '0;
	logic                        counterTick = 1'b0;
	logic [2:0][15:0]            compareValue = '0;
	logic [2:0]                  captureIn = '0;
	logic [2:0]                  moduleFlagClear = '0;
	logic [2:0]                  moduleOutputPin;
	logic [2:0]                  moduleEventFlag;
	logic [2:0][15:0]            capturedValue;
	logic                        arrayIrq;
	logic [15:0]                 d;
	int                          nFail = 0;
	int                          numChecks = 0;

	always #4 clk = ~clk;

	counter_array_cycle_and_module_mode uut (.clk(clk), .rstn(rstn), .sfrReq(sfrReq),
		.sfrRdData(sfrRdData), .arrayCounter(arrayCounter), .counterTick(counterTick),
		.compareValue(compareValue), .captureIn(captureIn), .moduleFlagClear(moduleFlagClear),
		.moduleOutputPin(moduleOutputPin), .moduleEventFlag(moduleEventFlag),
		.capturedValue(capturedValue), .arrayIrq(arrayIrq));

	// ********
	// Tasks
	// ********
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		numChecks++;
		if (seen !== exp) begin
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
			nFail++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk) sfrReq = '{a, v, 1'b1, 1'b0};
		@(negedge clk) sfrReq = '0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge clk) sfrReq = '{a, 8'h00, 1'b0, 1'b1};
		@(negedge clk) sfrReq = '0;
		d = {8'h00, sfrRdData};
	endtask : rd

	// Write then read in the very next cycle
	task automatic wrrd(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk) sfrReq = '{a, v, 1'b1, 1'b0};
		@(negedge clk) sfrReq = '{a, 8'h00, 1'b0, 1'b1};
		@(negedge clk) sfrReq = '0;
		d = {8'h00, sfrRdData};
	endtask : wrrd

	// Counter advance, optionally with a zero write to the cycle config
	task automatic tick(input logic [15:0] c, input logic w);
		@(negedge clk) begin
			arrayCounter = c;
			counterTick = 1'b1;
			sfrReq = '{8'hf7, 8'h00, w, 1'b0};
		end
		@(negedge clk) begin
			counterTick = 1'b0;
			sfrReq = '0;
		end
	endtask : tick

	task automatic cap(input logic v, input logic [15:0] c, input logic [15:0] e);
		@(negedge clk) begin
			arrayCounter = c;
			captureIn[0] = v;
		end
		repeat (2) @(negedge clk);
		chk(capturedValue[0], e);
	endtask : cap

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge clk);
		nFail++;
		report_and_stop();
	end

	// ********
	// Sequence
	// ********
	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(8'hda + 8'(i));
			chk(d, 16'h0000);
			wrrd(8'hda + 8'(i), 8'h5a ^ 8'(i));
			chk(d, {8'h00, 8'h5a ^ 8'(i)});
		end
		for (int i = 0; i < 3; i++) begin
			rd(8'hda + 8'(i));
			chk(d, {8'h00, 8'h5a ^ 8'(i)});
			// Park the module so its flags and interrupt stay quiet later
			wr(8'hda + 8'(i), 8'h00);
		end
		rd(8'hf7);
		chk(d, 16'h0000);
		wr(8'h10, 8'hff);
		rd(8'h10);
		chk(d, 16'h0000);
		wrrd(8'hf7, 8'hff);
		chk(d, 16'h00e3);
		wrrd(8'hf7, 8'h00);
		chk(d, 16'h0000);
		for (int l = 0; l < 4; l++) begin
			wr(8'hf7, 8'(l));
			tick(16'h00ff, 1'b0);
			rd(8'hf7);
			chk(d, {8'h00, 2'b00, l == 0, 3'b000, 2'(l)});
			tick(16'hffff >> (8 - l), 1'b0);
			rd(8'hf7);
			chk(d, {8'h00, 3'b001, 3'b000, 2'(l)});
		end
		tick(16'h07ff, 1'b1);
		rd(8'hf7);
		chk(d, 16'h0020);
		tick(16'h0000, 1'b1);
		rd(8'hf7);
		chk(d, 16'h0000);
		wr(8'hf7, 8'h60);
		@(negedge clk);
		chk(16'(arrayIrq), 16'h0001);
		wr(8'hf7, 8'h40);
		@(negedge clk);
		chk(16'(arrayIrq), 16'h0000);
		wr(8'hf7, 8'h00);
		compareValue[0] = 16'h1234;
		wr(8'hda, 8'h08);
		tick(16'h1234, 1'b0);
		chk(16'(moduleEventFlag[0]), 16'h0000);
		wr(8'hda, 8'h48);
		tick(16'h1234, 1'b0);
		chk(16'(moduleEventFlag[0]), 16'h0001);
		@(negedge clk) moduleFlagClear[0] = 1'b1;
		@(negedge clk) moduleFlagClear[0] = 1'b0;
		chk(16'(moduleEventFlag[0]), 16'h0000);
		wr(8'hda, 8'h44);
		tick(16'h1234, 1'b0);
		chk(16'(moduleOutputPin[0]), 16'h0001);
		tick(16'h1234, 1'b0);
		chk(16'(moduleOutputPin[0]), 16'h0000);
		compareValue[0] = 16'h0020;
		arrayCounter = 16'h0110;
		wr(8'hda, 8'h42);
		@(negedge clk);
		chk(16'(moduleOutputPin[0]), 16'h0001);
		wr(8'hf7, 8'h01);
		@(negedge clk);
		chk(16'(moduleOutputPin[0]), 16'h0000);
		wr(8'hf7, 8'h00);
		wr(8'hda, 8'hc2);
		@(negedge clk);
		chk(16'(moduleOutputPin[0]), 16'h0000);
		// Frequency output toggles on a low byte match alone
		wr(8'hda, 8'h46);
		tick(16'h0120, 1'b0);
		chk(16'(moduleOutputPin[0]), 16'h0001);
		wr(8'hda, 8'h20);
		cap(1'b1, 16'h0abc, 16'h0abc);
		cap(1'b0, 16'h0def, 16'h0abc);
		wr(8'hda, 8'h10);
		cap(1'b1, 16'h0123, 16'h0abc);
		cap(1'b0, 16'h0456, 16'h0456);
		wr(8'hda, 8'h30);
		cap(1'b1, 16'h0789, 16'h0789);
		cap(1'b0, 16'h0321, 16'h0321);
		wr(8'hda, 8'h31);
		@(negedge clk);
		chk(16'(arrayIrq), 16'h0001);
		report_and_stop();
	end
endmodule : tb_counter_array_cycle_and_module_mode
`default_nettype wire
